// ### verilog/pit_cfg.svh
`ifndef PIT_CFG_SVH
`define PIT_CFG_SVH
// What this block does
// - Chip select high: bus ignored, registers kept.
// - Eight-bit three-state data port, both directions.
// - Write strobe stores byte to counter or control.
// - Read strobe drives selected counter's value out.
// - Channel select picks counter; code three illegal.
// - Access format: latch, low, high, low-then-high.
// - Mode field picks mode; bit two ignored for 2,3.
// - Decimal flag picks binary or four-decade counting.
// - Control word clears that counter's count.
// - Host can read the cleared zero count until the count loads.
// - Host writes control word, then count value.
// - Two-byte loads go low then high, back to back.
// - Some modes start counting right after loading.
// - Each counter counts on its own clock input.
// - Gate starts, pauses and resumes counting per mode.
// - Wave pin follows programmed mode and count.
// - Loaded zero means 10000 hex counts in binary, 10000 decimal counts in BCD.
// - Latch command freezes a readable copy of count.
// - Counting is downward; square wave steps by two.

`define PIT_CW_SEL      7:6
`define PIT_CW_FMT      5:4
`define PIT_CW_MODE     3:1
`define PIT_CW_BCD      0
`define PIT_PORT_CTRL   2'h3
`define PIT_SEL_ILLEGAL 2'h3
`define PIT_FMT_LATCH   2'h0
`define PIT_FMT_LOW     2'h1
`define PIT_FMT_HIGH    2'h2
`define PIT_FMT_BOTH    2'h3
`define PIT_IDLE_BUS    8'hff

`define PIT_CLK_NS       4
`define PIT_T_SETUP_NS   30
`define PIT_T_STROBE_NS  150
`define PIT_T_HOLD_NS    20
`define PIT_T_RECOVER_NS 200
`define PIT_SETUP_CYC   ((`PIT_T_SETUP_NS + `PIT_CLK_NS - 1) / `PIT_CLK_NS)
`define PIT_STROBE_CYC  ((`PIT_T_STROBE_NS + `PIT_CLK_NS - 1) / `PIT_CLK_NS)
`define PIT_HOLD_CYC    ((`PIT_T_HOLD_NS + `PIT_CLK_NS - 1) / `PIT_CLK_NS)
`define PIT_RECOVER_CYC ((`PIT_T_RECOVER_NS + `PIT_CLK_NS - 1) / `PIT_CLK_NS)

`define PIT_REG_ACCESS  4'h0
`define PIT_REG_STATUS  4'h4
`define PIT_ACC_READ    16
`define PIT_ACC_PORT    9:8
`define PIT_ACC_DATA    7:0
`define PIT_ST_BUSY     8
`define PIT_ST_REFUSED  9
`endif

// ### verilog/pit_pkg.sv
package pit_pkg;
   typedef logic [15:0] count_t;
   typedef logic [2:0]  mode_t;
   typedef enum logic [2:0] {
      H_IDLE,
      H_SETUP,
      H_STROBE,
      H_HOLD,
      H_RECOVER,
      H_ACK
   } host_state_t;
endpackage : pit_pkg

// ### verilog/pit_bus_if.sv
`include "pit_cfg.svh"
interface pit_bus_if;
   logic       cs_n;
   logic       rd_n;
   logic       wr_n;
   logic [1:0] port_select;
   logic [7:0] host_d;
   logic       host_oe_n;
   logic [7:0] dev_d;
   logic       dev_oe_n;
   logic [7:0] host_data_bus;

   // The shared data wire: whoever enables wins, the host if both do, an idle bus floats high.
   assign host_data_bus = !host_oe_n ? host_d : (!dev_oe_n ? dev_d : `PIT_IDLE_BUS);

   modport device (input cs_n, rd_n, wr_n, port_select, host_data_bus, output dev_d, dev_oe_n);
   modport host (output cs_n, rd_n, wr_n, port_select, host_d, host_oe_n, input host_data_bus);
endinterface : pit_bus_if

// ### verilog/pit_device.sv
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`include "pit_cfg.svh"
module pit_device
   import pit_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_srst,
   pit_bus_if.device       bus,
   input  wire logic [2:0] i_counter_clock,
   input  wire logic [2:0] i_counter_gate,
   output logic [2:0]      o_counter_wave_pin
);

   function automatic count_t count_down(input count_t v, input logic bcd, input logic [1:0] step);
      count_t r;
      logic   borrow;
      r = v;
      for (int s = 0; s < 3; s++) begin
         if (s < int'(step)) begin
            if (bcd) begin
               borrow = 1'b1;
               for (int d = 0; d < 4; d++) begin
                  if (borrow) begin
                     if (r[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                     end else begin
                        r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                        borrow = 1'b0;
                     end
                  end
               end
            end else begin
               r = r - 16'h0001;
            end
         end
      end
      return r;
   endfunction : count_down

   function automatic mode_t mode_of(input logic [2:0] f);
      return f[1] ? {1'b0, f[1:0]} : f;
   endfunction : mode_of

   logic       wr_act_r;
   logic       rd_act_r;
   logic [1:0] rd_port_r;
   logic [7:0] dout_r;
   logic       doe_n_r;
   logic [7:0] rbyte [3];

   wire       wr_act  = !bus.cs_n && !bus.wr_n && bus.rd_n;
   wire       rd_act  = !bus.cs_n && !bus.rd_n && bus.wr_n;
   wire       wr_stb  = wr_act && !wr_act_r;
   wire       rd_end  = rd_act_r && !rd_act;
   wire [7:0] din     = bus.host_data_bus;
   wire       cw_wr   = wr_stb && (bus.port_select == `PIT_PORT_CTRL);
   wire [1:0] cw_sel  = din[`PIT_CW_SEL];
   wire       drive   = rd_act && (bus.port_select != `PIT_PORT_CTRL);
   wire [7:0] rd_sel  = (bus.port_select == 2'h2) ? rbyte[2] : ((bus.port_select == 2'h1) ? rbyte[1] : rbyte[0]);

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         wr_act_r  <= 1'b0;
         rd_act_r  <= 1'b0;
         rd_port_r <= 2'h0;
         dout_r    <= 8'h00;
         doe_n_r   <= 1'b1;
      end else begin
         wr_act_r  <= wr_act;
         rd_act_r  <= rd_act;
         rd_port_r <= bus.port_select;
         dout_r    <= drive ? rd_sel : 8'h00;
         doe_n_r   <= !drive;
      end
   end

   assign bus.dev_d    = dout_r;
   assign bus.dev_oe_n = doe_n_r;

   for (genvar i = 0; i < 3; i++) begin : g_ch
      logic [1:0] ch_id;
      mode_t      mode_r;
      logic       bcd_r;
      logic [1:0] fmt_r;
      count_t     cnt_r;
      count_t     init_r;
      count_t     latch_r;
      logic [7:0] lsb_r;
      logic       wflip_r;
      logic       rflip_r;
      logic       latched_r;
      logic       out_r;
      logic       run_r;
      logic       load_r;
      logic       have_r;
      logic       ck_r;
      logic       gate_r;
      logic       trig_r;

      assign ch_id = 2'(i);
      wire cw_hit  = cw_wr && (cw_sel == ch_id);
      wire dat_wr  = wr_stb && (bus.port_select == ch_id);
      wire rd_done = rd_end && (rd_port_r == ch_id);
      wire ce      = i_counter_clock[i] && !ck_r;
      wire gate    = i_counter_gate[i];
      wire rise    = gate && !gate_r;
      wire [1:0] fmt_w  = din[`PIT_CW_FMT];
      wire       done_w = dat_wr && ((fmt_r != `PIT_FMT_BOTH) || wflip_r);
      count_t rd_val;
      count_t new_init;
      assign rd_val   = latched_r ? latch_r : cnt_r;
      assign new_init = (fmt_r == `PIT_FMT_LOW)  ? {8'h00, din} :
                        (fmt_r == `PIT_FMT_HIGH) ? {din, 8'h00} : {din, lsb_r};
      wire [1:0] sq_step = cnt_r[0] ? (out_r ? 2'd1 : 2'd3) : 2'd2;
      wire start   = load_r || (trig_r && have_r);

      assign rbyte[i] = ((fmt_r == `PIT_FMT_HIGH) || ((fmt_r == `PIT_FMT_BOTH) && rflip_r)) ?
                        rd_val[15:8] : rd_val[7:0];
      assign o_counter_wave_pin[i] = out_r;

      always_ff @(posedge i_clk_sys) begin
         if (i_srst) begin
            mode_r    <= 3'h0;
            bcd_r     <= 1'b0;
            fmt_r     <= `PIT_FMT_LOW;
            cnt_r     <= 16'h0000;
            init_r    <= 16'h0000;
            latch_r   <= 16'h0000;
            lsb_r     <= 8'h00;
            wflip_r   <= 1'b0;
            rflip_r   <= 1'b0;
            latched_r <= 1'b0;
            out_r     <= 1'b1;
            run_r     <= 1'b0;
            load_r    <= 1'b0;
            have_r    <= 1'b0;
            // A high reset level keeps a pin already high at release from looking like an edge.
            ck_r      <= 1'b1;
            gate_r    <= 1'b1;
            trig_r    <= 1'b0;
         end else begin
            ck_r   <= i_counter_clock[i];
            gate_r <= gate;
            // A gate edge between two counter clocks is held until the next one.
            trig_r <= (trig_r && !ce) || rise;
            if ((mode_r == 3'h2 || mode_r == 3'h3) && !gate) begin
               out_r <= 1'b1;
            end
            if (ce) begin
               unique case (mode_r)
                  3'h0: begin
                     if (load_r) begin
                        cnt_r  <= init_r;
                        load_r <= 1'b0;
                        run_r  <= 1'b1;
                     end else if (run_r && gate) begin
                        cnt_r <= count_down(cnt_r, bcd_r, 2'd1);
                        if (cnt_r == 16'h0001) begin
                           out_r <= 1'b1;
                        end
                     end
                  end
                  3'h1, 3'h5: begin
                     if (trig_r && have_r) begin
                        cnt_r <= init_r;
                        run_r <= 1'b1;
                        out_r <= (mode_r == 3'h5);
                     end else if (run_r) begin
                        cnt_r <= count_down(cnt_r, bcd_r, 2'd1);
                        if (cnt_r == 16'h0001) begin
                           out_r <= (mode_r == 3'h1);
                           run_r <= 1'b0;
                        end
                     end else begin
                        out_r <= 1'b1;
                     end
                  end
                  3'h4: begin
                     if (start) begin
                        cnt_r  <= init_r;
                        load_r <= 1'b0;
                        run_r  <= 1'b1;
                        out_r  <= 1'b1;
                     end else if (run_r && gate) begin
                        cnt_r <= count_down(cnt_r, bcd_r, 2'd1);
                        if (cnt_r == 16'h0001) begin
                           out_r <= 1'b0;
                           run_r <= 1'b0;
                        end
                     end else begin
                        out_r <= 1'b1;
                     end
                  end
                  3'h2: begin
                     if (gate && start) begin
                        cnt_r  <= init_r;
                        load_r <= 1'b0;
                        run_r  <= 1'b1;
                        out_r  <= 1'b1;
                     end else if (gate && run_r) begin
                        if (cnt_r == 16'h0001) begin
                           cnt_r <= init_r;
                           out_r <= 1'b1;
                        end else begin
                           cnt_r <= count_down(cnt_r, bcd_r, 2'd1);
                           out_r <= (cnt_r != 16'h0002);
                        end
                     end
                  end
                  default: begin
                     if (gate && start) begin
                        cnt_r  <= init_r;
                        load_r <= 1'b0;
                        run_r  <= 1'b1;
                        out_r  <= 1'b1;
                     end else if (gate && run_r) begin
                        if (cnt_r == 16'(sq_step)) begin
                           cnt_r <= init_r;
                           out_r <= !out_r;
                        end else begin
                           cnt_r <= count_down(cnt_r, bcd_r, sq_step);
                        end
                     end
                  end
               endcase
            end
            if (dat_wr) begin
               if ((fmt_r == `PIT_FMT_BOTH) && !wflip_r) begin
                  lsb_r   <= din;
                  wflip_r <= 1'b1;
                  if (mode_r == 3'h0) begin
                     run_r <= 1'b0;
                  end
               end else begin
                  init_r  <= new_init;
                  wflip_r <= 1'b0;
               end
            end
            if (done_w) begin
               have_r <= 1'b1;
               if (mode_r == 3'h0 || mode_r == 3'h4 || !run_r) begin
                  load_r <= (mode_r != 3'h1) && (mode_r != 3'h5);
               end
               if (mode_r == 3'h0) begin
                  out_r <= 1'b0;
               end
            end
            if (rd_done) begin
               rflip_r <= (fmt_r == `PIT_FMT_BOTH) && !rflip_r;
               if ((fmt_r != `PIT_FMT_BOTH) || rflip_r) begin
                  latched_r <= 1'b0;
               end
            end
            if (cw_hit) begin
               if (fmt_w == `PIT_FMT_LATCH) begin
                  if (!latched_r) begin
                     latch_r   <= cnt_r;
                     latched_r <= 1'b1;
                     rflip_r   <= 1'b0;
                  end
               end else begin
                  mode_r    <= mode_of(din[`PIT_CW_MODE]);
                  bcd_r     <= din[`PIT_CW_BCD];
                  fmt_r     <= fmt_w;
                  cnt_r     <= 16'h0000;
                  out_r     <= (din[`PIT_CW_MODE] != 3'h0);
                  run_r     <= 1'b0;
                  load_r    <= 1'b0;
                  have_r    <= 1'b0;
                  wflip_r   <= 1'b0;
                  rflip_r   <= 1'b0;
                  latched_r <= 1'b0;
               end
            end
         end
      end
   end

endmodule : pit_device

// ### verilog/pit_host.sv
`include "pit_cfg.svh"
module pit_host
   import pit_pkg::*;
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_srst,
   pit_bus_if.host          bus,
   input  wire logic [3:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   output logic [31:0]      o_readdata,
   output logic             o_waitrequest
);

   host_state_t state_r;
   logic [5:0]  tick_r;
   logic        is_rd_r;
   logic        refused_r;
   logic [7:0]  rdata_r;
   logic        cs_n_r;
   logic        rd_n_r;
   logic        wr_n_r;
   logic [1:0]  port_r;
   logic [7:0]  hd_r;
   logic        hoe_n_r;
   logic [31:0] readdata_r;

   wire       hit_acc  = (i_address == `PIT_REG_ACCESS);
   wire       hit_st   = (i_address == `PIT_REG_STATUS);
   wire [1:0] w_port   = i_writedata[`PIT_ACC_PORT];
   wire [7:0] w_data   = i_writedata[`PIT_ACC_DATA];
   wire       w_rd     = i_writedata[`PIT_ACC_READ];
   // The illegal channel code is stopped here so the timer never sees it.
   wire       illegal  = !w_rd && (w_port == `PIT_PORT_CTRL) &&
                         (w_data[`PIT_CW_SEL] == `PIT_SEL_ILLEGAL);
   wire       last     = (tick_r == 6'd1);
   wire [31:0] st_word = {22'h0, refused_r, 1'b0, rdata_r};
   wire [31:0] rd_word = hit_st ? st_word : 32'h0000_0000;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state_r       <= H_IDLE;
         tick_r        <= 6'h00;
         is_rd_r       <= 1'b0;
         refused_r     <= 1'b0;
         rdata_r       <= 8'h00;
         cs_n_r        <= 1'b1;
         rd_n_r        <= 1'b1;
         wr_n_r        <= 1'b1;
         port_r        <= 2'h0;
         hd_r          <= 8'h00;
         hoe_n_r       <= 1'b1;
         readdata_r    <= 32'h0000_0000;
         o_waitrequest <= 1'b1;
      end else begin
         unique case (state_r)
            H_IDLE: begin
               if (i_read) begin
                  readdata_r    <= rd_word;
                  o_waitrequest <= 1'b0;
                  state_r       <= H_ACK;
               end else if (i_write && hit_acc && illegal) begin
                  refused_r     <= 1'b1;
                  o_waitrequest <= 1'b0;
                  state_r       <= H_ACK;
               end else if (i_write && hit_acc) begin
                  // Each order becomes one bus cycle, so a two-byte load stays in issue order.
                  refused_r <= 1'b0;
                  is_rd_r   <= w_rd;
                  port_r    <= w_port;
                  hd_r      <= w_data;
                  hoe_n_r   <= w_rd;
                  cs_n_r    <= 1'b0;
                  tick_r    <= 6'(`PIT_SETUP_CYC);
                  state_r   <= H_SETUP;
               end else if (i_write) begin
                  o_waitrequest <= 1'b0;
                  state_r       <= H_ACK;
               end
            end
            H_SETUP: begin
               tick_r <= tick_r - 6'h01;
               if (last) begin
                  rd_n_r  <= !is_rd_r;
                  wr_n_r  <= is_rd_r;
                  tick_r  <= 6'(`PIT_STROBE_CYC);
                  state_r <= H_STROBE;
               end
            end
            H_STROBE: begin
               tick_r <= tick_r - 6'h01;
               if (last) begin
                  if (is_rd_r) begin
                     rdata_r <= bus.host_data_bus;
                  end
                  rd_n_r  <= 1'b1;
                  wr_n_r  <= 1'b1;
                  tick_r  <= 6'(`PIT_HOLD_CYC);
                  state_r <= H_HOLD;
               end
            end
            H_HOLD: begin
               tick_r <= tick_r - 6'h01;
               if (last) begin
                  cs_n_r  <= 1'b1;
                  hoe_n_r <= 1'b1;
                  tick_r  <= 6'(`PIT_RECOVER_CYC);
                  state_r <= H_RECOVER;
               end
            end
            H_RECOVER: begin
               tick_r <= tick_r - 6'h01;
               if (last) begin
                  o_waitrequest <= 1'b0;
                  state_r       <= H_ACK;
               end
            end
            H_ACK: begin
               o_waitrequest <= 1'b1;
               state_r       <= H_IDLE;
            end
         endcase
      end
   end

   assign o_readdata      = readdata_r;
   assign bus.cs_n        = cs_n_r;
   assign bus.rd_n        = rd_n_r;
   assign bus.wr_n        = wr_n_r;
   assign bus.port_select = port_r;
   assign bus.host_d      = hd_r;
   assign bus.host_oe_n   = hoe_n_r;

endmodule : pit_host

// ### verification/pit_bus_assertions.sv
module pit_bus_assertions
(
   input wire logic       i_clk_sys,
   input wire logic       i_srst,
   input wire logic       cs_n,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic [1:0] port_select,
   input wire logic [7:0] host_d,
   input wire logic       host_oe_n,
   input wire logic [7:0] dev_d,
   input wire logic       dev_oe_n,
   input wire logic [7:0] host_data_bus
);
   timeunit 1ns;
   timeprecision 1ps;

   wire rd_req = !cs_n && !rd_n && wr_n && (port_select != 2'h3);
   wire wr_req = !cs_n && !wr_n && rd_n;
   wire addr_on = !cs_n && !host_oe_n;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);

   // Widths are counted in system clocks, so these hold for any slower host timing too.
   sequence s_wr_held;
      !wr_n [*8];
   endsequence
   sequence s_addr_hold;
      (!cs_n && !host_oe_n) [*4];
   endsequence

   AST_CS_IDLE: assert property (cs_n |-> dev_oe_n)
      else $error("Device drives the bus while deselected.");
   AST_DRIVE_CAUSE: assert property (!dev_oe_n |-> $past(rd_req))
      else $error("Device drives without a counter read strobe.");
   AST_READ_ANSWER: assert property (rd_req && $past(rd_req) |->
      !dev_oe_n && host_data_bus == dev_d)
      else $error("Device does not answer a counter read.");
   AST_NO_CLASH: assert property (!dev_oe_n |-> host_oe_n)
      else $error("Both ends drive the data bus.");
   AST_WR_WIDTH: assert property ($fell(wr_n) |-> s_wr_held)
      else $error("Write strobe too short.");
   AST_WR_SETUP: assert property ($fell(wr_n) |-> $past(addr_on, 7) && rd_n)
      else $error("Write strobe without address setup.");
   AST_WR_STABLE: assert property (wr_req && $past(wr_req) |->
      $stable(host_data_bus) && $stable(port_select) && host_data_bus == host_d)
      else $error("Write data or port moved during the strobe.");
   AST_WR_HOLD: assert property ($rose(wr_n) |-> s_addr_hold)
      else $error("Chip select or data released too early after write.");
   AST_RD_ONLY: assert property (!rd_n |-> wr_n && host_oe_n)
      else $error("Host drives or writes during a read.");
   AST_NO_ILLEGAL: assert property (wr_req && port_select == 2'h3 |-> host_data_bus[7:6] != 2'h3)
      else $error("Illegal channel select reached the bus.");
endmodule : pit_bus_assertions

// ### verification/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        srst;
   logic [3:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [2:0]  cnt_clk = 3'h0;
   logic [2:0]  gate;
   logic [2:0]  wave;
   logic [3:0]  div = 4'h0;
   logic [31:0] st;
   int          error_cnt;
   int          comparisons;

   pit_bus_if bus ();

   pit_host i_pit_host (.i_clk_sys(clk), .i_srst(srst), .bus(bus.host), .i_address(address), .i_read(read),
      .i_write(write), .i_writedata(writedata), .o_readdata(readdata), .o_waitrequest(waitrequest));

   pit_device i_pit_device (.i_clk_sys(clk), .i_srst(srst), .bus(bus.device), .i_counter_clock(cnt_clk),
      .i_counter_gate(gate), .o_counter_wave_pin(wave));

   pit_bus_assertions i_pit_bus_assertions (.i_clk_sys(clk), .i_srst(srst), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
      .wr_n(bus.wr_n), .port_select(bus.port_select), .host_d(bus.host_d), .host_oe_n(bus.host_oe_n),
      .dev_d(bus.dev_d), .dev_oe_n(bus.dev_oe_n), .host_data_bus(bus.host_data_bus));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Counter clocks run at one sixteenth of the system clock, slow enough to watch a count.
   always @(posedge clk) begin
      div <= div + 4'h1;
      cnt_clk <= {3{div[3]}};
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check

   task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= rd;
      write <= !rd;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 300);
      st = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 300) begin
         check(32'h0, 32'h1, "bus timeout");
      end
      @(posedge clk);
   endtask : av

   task automatic acc(input logic [1:0] p, input logic [7:0] d, input logic rd);
      av(1'b0, 4'h0, {15'h0, rd, 6'h0, p, d});
   endtask : acc

   task automatic rd_byte(input logic [1:0] p, input logic [7:0] exp, input string msg);
      acc(p, 8'h00, 1'b1);
      av(1'b1, 4'h4, 32'h0);
      check({24'h0, st[7:0]}, {24'h0, exp}, msg);
   endtask : rd_byte

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      #100000;
      error_cnt++;
      end_sim();
   end

   initial begin
      srst = 1'b1;
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      gate = 3'b001;
      error_cnt = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      for (int m = 0; m < 8; m++) begin
         acc(2'h3, {4'h1, m[2:0], 1'b0}, 1'b0);
         check({31'h0, wave[0]}, (m == 0) ? 32'h0 : 32'h1, "wave level after mode set");
      end
      $display("test modes done");
      // The count is long enough to outlast the slow host write cycle itself.
      acc(2'h3, 8'h10, 1'b0);
      acc(2'h0, 8'h20, 1'b0);
      repeat (300) @(posedge clk);
      check({31'h0, wave[0]}, 32'h0, "terminal count too early");
      repeat (200) @(posedge clk);
      check({31'h0, wave[0]}, 32'h1, "terminal count not reached");
      acc(2'h3, 8'h10, 1'b0);
      check({31'h0, wave[0]}, 32'h0, "control word did not restart");
      $display("test count done");
      acc(2'h3, 8'hc0, 1'b0);
      av(1'b1, 4'h4, 32'h0);
      check({31'h0, st[9]}, 32'h1, "illegal select not refused");
      acc(2'h3, 8'h00, 1'b1);
      av(1'b1, 4'h4, 32'h0);
      check({24'h0, st[7:0]}, 32'hff, "control port read drove bus");
      check({31'h0, st[9]}, 32'h0, "refused flag not cleared");
      av(1'b1, 4'h8, 32'h0);
      check(st, 32'h0, "unmapped read not zero");
      $display("test refuse done");
      acc(2'h3, 8'h50, 1'b0);
      acc(2'h1, 8'h05, 1'b0);
      repeat (40) @(posedge clk);
      check({31'h0, wave[1]}, 32'h0, "gated wave left its mode level");
      rd_byte(2'h1, 8'h05, "low byte read");
      acc(2'h3, 8'h40, 1'b0);
      // A new count loaded after the latch must not show until the latched copy is read.
      acc(2'h1, 8'h07, 1'b0);
      rd_byte(2'h1, 8'h05, "latched read");
      rd_byte(2'h1, 8'h07, "latch not released");
      acc(2'h3, 8'h60, 1'b0);
      acc(2'h1, 8'haa, 1'b0);
      repeat (40) @(posedge clk);
      rd_byte(2'h1, 8'haa, "high byte read");
      $display("test formats done");
      acc(2'h3, 8'hb1, 1'b0);
      acc(2'h2, 8'h34, 1'b0);
      acc(2'h2, 8'h12, 1'b0);
      repeat (40) @(posedge clk);
      rd_byte(2'h2, 8'h34, "two byte low");
      rd_byte(2'h2, 8'h12, "two byte high");
      acc(2'h2, 8'h10, 1'b0);
      acc(2'h2, 8'h00, 1'b0);
      repeat (40) @(posedge clk);
      gate <= 3'b101;
      repeat (120) @(posedge clk);
      check({31'h0, wave[2]}, 32'h0, "decade count ended early");
      repeat (80) @(posedge clk);
      check({31'h0, wave[2]}, 32'h1, "decade count not ten steps");
      $display("test decade done");
      end_sim();
   end
endmodule : tb
